/* hdl/cas_pkg.sv */
// Shared constants, types and helpers for the CPU address sequencer
package cas_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int PC_W = 12;
  localparam int DM_AW = 7;
  localparam int NIB_W = 4;
  localparam int FLAG_W = 5;
  localparam int SP_W = 3;
  localparam int RS_DEPTH = 5;
  localparam int IS_DEPTH = 3;
  localparam int IS_LVL_W = 2;
  localparam int DM_WORDS = 128;
  localparam int CTL_WORDS = 64;

  // ----------------------------------------
  // Program space
  // ----------------------------------------
  localparam logic [PC_W-1:0] RESET_ADDR = 12'h000;
  localparam logic [PC_W-1:0] CALL_MASK = 12'h7ff;
  localparam logic [PC_W-1:0] VEC_LAST = 12'h005;
  localparam logic [PC_W-1:0] PAGE_STEPS = 12'h800;

  // ----------------------------------------
  // Data memory map
  // ----------------------------------------
  localparam logic [DM_AW-1:0] ADDR_AR3 = 7'h74;
  localparam logic [DM_AW-1:0] ADDR_AR2 = 7'h75;
  localparam logic [DM_AW-1:0] ADDR_AR1 = 7'h76;
  localparam logic [DM_AW-1:0] ADDR_AR0 = 7'h77;
  localparam logic [DM_AW-1:0] ADDR_WR = 7'h78;
  localparam logic [DM_AW-1:0] ADDR_BANK = 7'h79;
  localparam logic [DM_AW-1:0] ADDR_IXH = 7'h7a;
  localparam logic [DM_AW-1:0] ADDR_IXM = 7'h7b;
  localparam logic [DM_AW-1:0] ADDR_IXL = 7'h7c;
  localparam logic [DM_AW-1:0] ADDR_BANKPTR = 7'h7d;
  localparam logic [DM_AW-1:0] ADDR_ROWPSW = 7'h7e;
  localparam logic [DM_AW-1:0] ADDR_PSW = 7'h7f;
  localparam logic [DM_AW-1:0] SYS_FIRST = 7'h74;
  localparam logic [DM_AW-1:0] CTL_LAST = 7'h3f;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BCD_BIT = 0;
  localparam int CMP_BIT = 3;
  localparam int CY_BIT = 2;
  localparam int Z_BIT = 1;
  localparam int IXE_BIT = 0;
  localparam int ROW_LSB = 4;
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;

  // ----------------------------------------
  // Instruction-level commands
  // ----------------------------------------
  typedef enum logic [3:0] {
    CAS_OP_HOLD = 4'h0,
    CAS_OP_STEP = 4'h1,
    CAS_OP_BRANCH = 4'h2,
    CAS_OP_CALL = 4'h3,
    CAS_OP_BR_IND = 4'h4,
    CAS_OP_CALL_IND = 4'h5,
    CAS_OP_TABLE_READ = 4'h6,
    CAS_OP_RET = 4'h7,
    CAS_OP_RET_SKIP = 4'h8,
    CAS_OP_RET_IRQ = 4'h9,
    CAS_OP_IRQ = 4'ha
  } cas_op_t;

  typedef struct packed {
    cas_op_t op;
    logic [PC_W-1:0] target;
    logic [2:0] vector;
  } cas_cmd_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [DM_AW-1:0] addr;
    logic [NIB_W-1:0] wdata;
  } cas_mem_t;

  typedef struct packed {
    logic we;
    logic bcd;
    logic cmp;
    logic cy;
    logic z;
  } cas_alu_t;

  typedef struct packed {
    logic [15:0] table_address_pointer;
    logic [11:0] index_pointer;
    logic [6:0] working_row_pointer;
    logic [NIB_W-1:0] bank_select;
    logic [NIB_W-1:0] window_nibble;
    logic [FLAG_W-1:0] cpu_status_word;
  } cas_view_t;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] cas_row(input logic [DM_AW-1:0] a);
    cas_row = a[DM_AW-1:ROW_LSB];
  endfunction

  function automatic logic [3:0] cas_col(input logic [DM_AW-1:0] a);
    cas_col = a[ROW_LSB-1:0];
  endfunction

  function automatic logic [PC_W-1:0] cas_inc(input logic [PC_W-1:0] pc);
    cas_inc = pc + 12'h001;
  endfunction

endpackage

/* hdl/cas_lifo.sv */
// Small last-in first-out store with an entry counter
`timescale 1ns/1ps

module cas_lifo
  import cas_pkg::*;
#(
  parameter int W = 12,
  parameter int DEPTH = 5,
  parameter int LW = 3
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] din,
  output logic [W-1:0] top,
  output logic [LW-1:0] level
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [LW-1:0] level;
  } cas_lifo_state_t;

  localparam logic [LW-1:0] FULL = LW'(DEPTH);
  localparam logic [LW-1:0] ONE = LW'(1);

  cas_lifo_state_t state_reg;
  cas_lifo_state_t state_next;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Push when full and pop when empty are dropped; nothing wraps
  always_comb begin
    state_next = state_reg;
    if (push && state_reg.level != FULL) begin
      state_next.mem[state_reg.level] = din;
      state_next.level = state_reg.level + ONE;
    end else if (pop && state_reg.level != '0) begin
      state_next.level = state_reg.level - ONE;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  assign top = (state_reg.level == '0) ? '0 : state_reg.mem[state_reg.level - ONE];
  assign level = state_reg.level;

endmodule

/* hdl/cas_sequencer.sv */
// Program counter sequencing, stacks, data memory and register file
`timescale 1ns/1ps

// Contract
// - One 16-bit step per address, 2K-step pages
// - Direct call targets confined to page 0
// - Branch, indirect call, table reach full range
// - Program counter is plain 12-bit binary counter
// - Counter increments unless an instruction loads it; here it increments only on step and keeps its value on hold
// - Reset, jumps, returns, interrupts load new address
// - Indirect jumps and table read use pointer
// - Every return reloads from selected stack entry
// - Stack index is a 3-bit counter
// - Return stack holds five counter-wide entries
// - Interrupt flag stack: three 5-bit entries
// - Calls and table reads push before redirect
// - Interrupt saves address, status, then clears status
// - Data memory addresses are seven bits
// - Row is top three bits, column low four
// - Each data memory location holds one nibble
// - Working pointer is bank nibble plus row bits
// - System registers 74H-7FH are ordinary memory
// - Register file holds 128 nibbles, rows 0-7
// - Register file 00H-3FH is control area
// - Register file 40H-7FH shares data memory storage
// - Reset starts at 0000H, vectors up to 0005H
// - Register file via regfile_read/regfile_write; upper half also moves
// - Status flags mirror arithmetic unit flip-flops
module cas_sequencer
  import cas_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire cas_cmd_t cmd,
  input wire cas_mem_t dm,
  input wire cas_mem_t rf,
  input wire cas_alu_t alu,
  output logic [PC_W-1:0] instr_pointer,
  output logic [NIB_W-1:0] dm_rdata,
  output logic [NIB_W-1:0] rf_rdata,
  output logic [2:0] dm_row,
  output logic [3:0] dm_col,
  output logic skip_next,
  output logic [SP_W-1:0] stack_index,
  output logic [IS_LVL_W-1:0] irq_level,
  output cas_view_t view
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [DM_WORDS-1:0][NIB_W-1:0] mem;
    logic [CTL_WORDS-1:0][NIB_W-1:0] ctl;
    logic [NIB_W-1:0] dm_rdata;
    logic [NIB_W-1:0] rf_rdata;
    logic [2:0] dm_row;
    logic [3:0] dm_col;
    logic skip;
    cas_view_t view;
  } cas_state_t;

  cas_state_t state_reg;
  cas_state_t state_next;

  logic rs_push;
  logic rs_pop;
  logic [PC_W-1:0] rs_din;
  logic [PC_W-1:0] rs_top;
  logic [SP_W-1:0] rs_level;
  logic is_push;
  logic is_pop;
  logic [FLAG_W-1:0] is_din;
  logic [FLAG_W-1:0] is_top;
  logic [IS_LVL_W-1:0] is_level;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [FLAG_W-1:0] status_of(input logic [DM_WORDS-1:0][NIB_W-1:0] m);
    status_of = {m[ADDR_ROWPSW][BCD_BIT], m[ADDR_PSW]};
  endfunction

  function automatic logic [PC_W-1:0] pointer_of(input logic [DM_WORDS-1:0][NIB_W-1:0] m);
    pointer_of = {m[ADDR_AR2], m[ADDR_AR1], m[ADDR_AR0]};
  endfunction

  // ----------------------------------------
  // Stacks
  // ----------------------------------------
  // Return stack: five entries as wide as the counter
  cas_lifo #(
    .W(PC_W),
    .DEPTH(RS_DEPTH),
    .LW(SP_W)
  ) u_return_addr_stack (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .push(rs_push),
    .pop(rs_pop),
    .din(rs_din),
    .top(rs_top),
    .level(rs_level)
  );

  // Flag stack: three 5-bit entries for nested levels
  cas_lifo #(
    .W(FLAG_W),
    .DEPTH(IS_DEPTH),
    .LW(IS_LVL_W)
  ) u_irq_flag_stack (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .push(is_push),
    .pop(is_pop),
    .din(is_din),
    .top(is_top),
    .level(is_level)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.skip = 1'b0;
    rs_push = 1'b0;
    rs_pop = 1'b0;
    rs_din = cas_inc(state_reg.pc);
    is_push = 1'b0;
    is_pop = 1'b0;
    is_din = status_of(state_reg.mem);

    // Nibble-wide store, seven-bit address
    if (dm.re) begin
      state_next.dm_rdata = state_reg.mem[dm.addr];
      state_next.dm_row = cas_row(dm.addr);
      state_next.dm_col = cas_col(dm.addr);
    end
    if (dm.we) begin
      state_next.mem[dm.addr] = dm.wdata;
    end

    // Regfile_read/regfile_write: low half is control area, upper half is shared
    if (rf.re) begin
      if (rf.addr <= CTL_LAST) begin
        state_next.rf_rdata = state_reg.ctl[rf.addr[5:0]];
      end else begin
        state_next.rf_rdata = state_reg.mem[rf.addr];
      end
    end
    if (rf.we) begin
      if (rf.addr <= CTL_LAST) begin
        state_next.ctl[rf.addr[5:0]] = rf.wdata;
      end else begin
        state_next.mem[rf.addr] = rf.wdata;
      end
    end

    // Arithmetic flags land after software writes, so the ALU wins
    if (alu.we) begin
      state_next.mem[ADDR_ROWPSW][BCD_BIT] = alu.bcd;
      state_next.mem[ADDR_PSW][CMP_BIT] = alu.cmp;
      state_next.mem[ADDR_PSW][CY_BIT] = alu.cy;
      state_next.mem[ADDR_PSW][Z_BIT] = alu.z;
    end

    // Sequencing; counter is plain binary and wraps
    unique case (cmd.op)
      CAS_OP_HOLD: begin
      end
      CAS_OP_STEP: begin
        state_next.pc = cas_inc(state_reg.pc);
      end
      CAS_OP_BRANCH: begin
        state_next.pc = cmd.target;
      end
      CAS_OP_CALL: begin
        rs_push = 1'b1;
        state_next.pc = cmd.target & CALL_MASK;
      end
      CAS_OP_BR_IND: begin
        state_next.pc = pointer_of(state_reg.mem);
      end
      CAS_OP_CALL_IND, CAS_OP_TABLE_READ: begin
        rs_push = 1'b1;
        state_next.pc = pointer_of(state_reg.mem);
      end
      CAS_OP_RET: begin
        rs_pop = 1'b1;
        state_next.pc = rs_top;
      end
      CAS_OP_RET_SKIP: begin
        rs_pop = 1'b1;
        state_next.pc = rs_top;
        state_next.skip = 1'b1;
      end
      CAS_OP_RET_IRQ: begin
        rs_pop = 1'b1;
        is_pop = 1'b1;
        state_next.pc = rs_top;
        if (is_level != '0) begin
          state_next.mem[ADDR_ROWPSW][BCD_BIT] = is_top[FLAG_W-1];
          state_next.mem[ADDR_PSW] = is_top[NIB_W-1:0];
        end
      end
      CAS_OP_IRQ: begin
        // Return address is the instruction not yet executed
        rs_din = state_reg.pc;
        rs_push = 1'b1;
        is_push = 1'b1;
        state_next.mem[ADDR_ROWPSW][BCD_BIT] = 1'b0;
        state_next.mem[ADDR_PSW] = NIB_ZERO;
        // Vectors above the last slot are clamped to it
        if ({9'h000, cmd.vector} > VEC_LAST) begin
          state_next.pc = VEC_LAST;
        end else begin
          state_next.pc = {9'h000, cmd.vector};
        end
      end
      default: begin
      end
    endcase

    // Registered views of the system block
    state_next.view.table_address_pointer = {state_next.mem[ADDR_AR3], state_next.mem[ADDR_AR2],
                                             state_next.mem[ADDR_AR1], state_next.mem[ADDR_AR0]};
    state_next.view.window_nibble = state_next.mem[ADDR_WR];
    state_next.view.bank_select = state_next.mem[ADDR_BANK];
    state_next.view.index_pointer = {state_next.mem[ADDR_IXH], state_next.mem[ADDR_IXM],
                                     state_next.mem[ADDR_IXL]};
    state_next.view.working_row_pointer = {state_next.mem[ADDR_BANKPTR],
                                           state_next.mem[ADDR_ROWPSW][3:1]};
    state_next.view.cpu_status_word = status_of(state_next.mem);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Storage clears at reset; the counter restarts at the reset address
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
      state_reg.pc <= RESET_ADDR;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Stack outputs come straight from the counters in the stacks
  assign stack_index = rs_level;
  assign irq_level = is_level;

  assign instr_pointer = state_reg.pc;
  assign dm_rdata = state_reg.dm_rdata;
  assign rf_rdata = state_reg.rf_rdata;
  assign dm_row = state_reg.dm_row;
  assign dm_col = state_reg.dm_col;
  assign skip_next = state_reg.skip;
  assign view = state_reg.view;

endmodule

/* testbench/cas_seq_asserts.sv */
// Assertion checker for the CPU address sequencer
`timescale 1ns/1ps

module cas_seq_asserts
  import cas_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire cas_cmd_t cmd,
  input wire cas_mem_t dm,
  input wire cas_mem_t rf,
  input wire cas_alu_t alu,
  input wire logic [PC_W-1:0] instr_pointer,
  input wire logic [NIB_W-1:0] dm_rdata,
  input wire logic [NIB_W-1:0] rf_rdata,
  input wire logic [2:0] dm_row,
  input wire logic [3:0] dm_col,
  input wire logic skip_next,
  input wire logic [SP_W-1:0] stack_index,
  input wire logic [IS_LVL_W-1:0] irq_level,
  input wire cas_view_t view
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  chk_reset_start: assert property (
    $rose(resetn) |-> instr_pointer == RESET_ADDR)
    else $error("pc not at start after reset");
  chk_step_inc: assert property (
    ce && cmd.op == CAS_OP_STEP |=> instr_pointer == $past(instr_pointer) + 12'h001)
    else $error("pc did not step");
  chk_call_page: assert property (
    ce && cmd.op == CAS_OP_CALL |=> instr_pointer == ($past(cmd.target) & CALL_MASK))
    else $error("call left page zero");
  chk_branch_full: assert property (
    ce && cmd.op == CAS_OP_BRANCH |=> instr_pointer == $past(cmd.target))
    else $error("branch target wrong");
  chk_ind_ptr: assert property (
    ce && cmd.op inside {CAS_OP_BR_IND, CAS_OP_CALL_IND, CAS_OP_TABLE_READ}
    |=> instr_pointer == $past(view.table_address_pointer[11:0]))
    else $error("indirect target wrong");
  chk_call_push: assert property (
    ce && cmd.op == CAS_OP_CALL && stack_index < 3'h5 |=> stack_index == $past(stack_index) + 3'h1)
    else $error("call did not push");
  chk_irq_clear: assert property (
    ce && cmd.op == CAS_OP_IRQ |=> view.cpu_status_word == 5'h00 && instr_pointer <= VEC_LAST)
    else $error("interrupt entry wrong");
  chk_skip_pulse: assert property (
    ce && cmd.op == CAS_OP_RET_SKIP |=> skip_next)
    else $error("skip pulse missing");
  chk_row_col: assert property (
    ce && dm.re |=> dm_row == $past(dm.addr[6:4]) && dm_col == $past(dm.addr[3:0]))
    else $error("row or column decode wrong");
  cov_call: cover property (ce && cmd.op == CAS_OP_CALL);
  cov_irq: cover property (ce && cmd.op == CAS_OP_IRQ);
  cov_skip: cover property (skip_next);
endmodule

bind cas_sequencer cas_seq_asserts u_chk (.mclk(mclk), .resetn(resetn), .ce(ce), .cmd(cmd), .dm(dm),
  .rf(rf), .alu(alu), .instr_pointer(instr_pointer), .dm_rdata(dm_rdata), .rf_rdata(rf_rdata),
  .dm_row(dm_row), .dm_col(dm_col), .skip_next(skip_next), .stack_index(stack_index),
  .irq_level(irq_level), .view(view));

/* testbench/test_cas_sequencer.sv */
// Self-checking bench for the CPU address sequencer
`timescale 1ns/1ps

module test_cas_sequencer
  import cas_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b0;
  cas_cmd_t cmd = '0;
  cas_mem_t dm = '0;
  cas_mem_t rf = '0;
  cas_alu_t alu = '0;
  logic [PC_W-1:0] instr_pointer;
  logic [NIB_W-1:0] dm_rdata;
  logic [NIB_W-1:0] rf_rdata;
  logic [2:0] dm_row;
  logic [3:0] dm_col;
  logic skip_next;
  logic [SP_W-1:0] stack_index;
  logic [IS_LVL_W-1:0] irq_level;
  cas_view_t view;
  logic [3:0] arn [4] = '{4'h1, 4'he, 4'h5, 4'ha};
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #2 mclk = ~mclk;

  cas_sequencer u_dut (.mclk(mclk), .resetn(resetn), .ce(ce), .cmd(cmd), .dm(dm), .rf(rf),
    .alu(alu), .instr_pointer(instr_pointer), .dm_rdata(dm_rdata), .rf_rdata(rf_rdata),
    .dm_row(dm_row), .dm_col(dm_col), .skip_next(skip_next), .stack_index(stack_index),
    .irq_level(irq_level), .view(view));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report;
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One instruction-level command, then back to hold
  task automatic op(input cas_op_t o, input logic [PC_W-1:0] t, input logic [2:0] v);
    @(posedge mclk);
    cmd <= '{o, t, v};
    @(posedge mclk);
    cmd <= '0;
    #1;
  endtask

  // Nibble access: r picks register file, w picks write
  task automatic mem(input logic r, input logic w, input logic [6:0] a, input logic [3:0] d);
    @(posedge mclk);
    if (r) begin
      rf <= '{w, !w, a, d};
    end else begin
      dm <= '{w, !w, a, d};
    end
    @(posedge mclk);
    rf <= '0;
    dm <= '0;
    #1;
  endtask

  // Hang guard, well above the hundred-odd cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      final_report;
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    ce <= 1'b1;
    #1;
    check(instr_pointer, 12'h000);
    check(view, 48'h0);
    repeat (3) op(CAS_OP_STEP, 12'h000, 3'h0);
    check(instr_pointer, 12'h003);
    op(CAS_OP_BRANCH, 12'hffe, 3'h0);
    op(CAS_OP_STEP, 12'h000, 3'h0);
    check(instr_pointer, 12'hfff);
    op(CAS_OP_CALL, 12'h9ab, 3'h0);
    check(instr_pointer, 12'h1ab);
    check(stack_index, 3'h1);
    for (int i = 0; i < 4; i++) mem(1'b0, 1'b1, SYS_FIRST + 7'(i), arn[i]);
    check(view.table_address_pointer, 16'h1e5a);
    op(CAS_OP_BR_IND, 12'h000, 3'h0);
    check(instr_pointer, 12'he5a);
    op(CAS_OP_TABLE_READ, 12'h000, 3'h0);
    check(stack_index, 3'h2);
    op(CAS_OP_RET, 12'h000, 3'h0);
    check(instr_pointer, 12'he5b);
    op(CAS_OP_CALL_IND, 12'h000, 3'h0);
    check({stack_index, instr_pointer}, 15'h2e5a);
    op(CAS_OP_RET, 12'h000, 3'h0);
    check(instr_pointer, 12'he5c);
    op(CAS_OP_RET_SKIP, 12'h000, 3'h0);
    check({skip_next, instr_pointer}, 13'h1000);
    // Enable low must freeze the counter
    @(posedge mclk);
    ce <= 1'b0;
    op(CAS_OP_STEP, 12'h000, 3'h0);
    check(instr_pointer, 12'h000);
    @(posedge mclk);
    ce <= 1'b1;
    // Sixth call overflows and must not disturb the first entry
    repeat (6) op(CAS_OP_CALL, 12'h123, 3'h0);
    check(stack_index, 3'h5);
    repeat (5) op(CAS_OP_RET, 12'h000, 3'h0);
    check({stack_index, instr_pointer}, 15'h0001);
    mem(1'b0, 1'b1, ADDR_PSW, 4'hf);
    mem(1'b0, 1'b1, ADDR_ROWPSW, 4'h1);
    check(view.cpu_status_word, 5'h1f);
    op(CAS_OP_IRQ, 12'h000, 3'h3);
    check({irq_level, view.cpu_status_word, instr_pointer}, 19'h20003);
    @(posedge mclk);
    alu <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    @(posedge mclk);
    alu <= '0;
    #1;
    check(view.cpu_status_word, 5'h0a);
    op(CAS_OP_RET_IRQ, 12'h000, 3'h0);
    check({irq_level, view.cpu_status_word, instr_pointer}, 19'h1f001);
    // Out-of-range vector lands on the last slot
    op(CAS_OP_IRQ, 12'h000, 3'h7);
    check(instr_pointer, 12'h005);
    op(CAS_OP_RET_IRQ, 12'h000, 3'h0);
    check(instr_pointer, 12'h001);
    mem(1'b0, 1'b1, ADDR_BANKPTR, 4'h3);
    mem(1'b0, 1'b1, ADDR_ROWPSW, 4'ha);
    check(view.working_row_pointer, 7'h1d);
    mem(1'b0, 1'b1, ADDR_IXH, 4'h4);
    mem(1'b0, 1'b1, ADDR_IXM, 4'hb);
    mem(1'b0, 1'b1, ADDR_IXL, 4'h2);
    check(view.index_pointer, 12'h4b2);
    mem(1'b0, 1'b1, ADDR_WR, 4'h6);
    mem(1'b0, 1'b1, ADDR_BANK, 4'h9);
    check({view.bank_select, view.window_nibble}, 8'h96);
    mem(1'b1, 1'b1, 7'h45, 4'h9);
    mem(1'b0, 1'b0, 7'h45, 4'h0);
    check(dm_rdata, 4'h9);
    mem(1'b0, 1'b1, 7'h50, 4'h6);
    mem(1'b1, 1'b0, 7'h50, 4'h0);
    check(rf_rdata, 4'h6);
    mem(1'b1, 1'b1, 7'h10, 4'h7);
    mem(1'b0, 1'b1, 7'h10, 4'h2);
    mem(1'b1, 1'b0, 7'h10, 4'h0);
    check(rf_rdata, 4'h7);
    mem(1'b0, 1'b1, 7'h1a, 4'hc);
    mem(1'b0, 1'b0, 7'h1a, 4'h0);
    check(dm_rdata, 4'hc);
    check({dm_row, dm_col}, 7'h1a);
    final_report;
  end
endmodule
